// [core/tcs_pkg.sv]
// Constants, field layout and source codes of the timer clock source select.
// Assumes one 100 MHz peripheral clock and a plain strobe register port.
//
// How it works
// - Code 000 counts every peripheral clock; reset value.
// - Channel 0 codes 100..111 select pins A..D.
// - Channels 1, 3 code 001 divide by four.
// - Channels 1, 2 codes 100, 101: pins A, B.
// - Divide 256: channel 1 code 110, channel 3 code 100.
// - Channel 1 code 111 counts channel 2 wraps.
// - Channel 1 phase mode ignores its select.
// - Channel 2 code 010 divides by sixteen.
// - Channel 2 code 110 selects pin C.
// - Channel 2 phase mode ignores its select.
// - Channel 3 codes 110, 111: pins A, B.
// - Select field bits 2..0, independent per channel.
// - Edge choice only for divided or pin sources.
// - Control clears on power-on or standby only.

package tcs_pkg;

    // Widths
    localparam int NUM_CH = 4;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int CNT_W  = 16;
    localparam int PRE_W  = 10;
    localparam int CTL_W  = 5;

    // Register map
    localparam logic [ADDR_W-1:0] ADDR_CTRL0 = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_MODE  = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_CNT0  = 4'h8;

    // Control register fields
    localparam int SEL_LSB  = 0;
    localparam int SEL_MSB  = 2;
    localparam int EDGE_LSB = 3;
    localparam int EDGE_MSB = 4;
    localparam logic [CTL_W-1:0] CTRL_RST = 5'h00;

    // Mode register bits
    localparam int MODE_PH1_BIT = 0;
    localparam int MODE_PH2_BIT = 1;
    localparam logic [1:0] MODE_RST = 2'h0;

    // Edge codes, bit 1 set means both edges
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam int EDGE_BOTH_BIT     = 1;

    // Prescaler taps as log2 of the ratio
    localparam int LG_DIV4    = 2;
    localparam int LG_DIV16   = 4;
    localparam int LG_DIV64   = 6;
    localparam int LG_DIV256  = 8;
    localparam int LG_DIV1024 = 10;

    // Counter limits
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
    localparam logic [PRE_W-1:0] PRE_ONE  = 10'h001;

    // Select codes
    localparam logic [2:0] SEL_C0 = 3'h0;
    localparam logic [2:0] SEL_C1 = 3'h1;
    localparam logic [2:0] SEL_C2 = 3'h2;
    localparam logic [2:0] SEL_C3 = 3'h3;
    localparam logic [2:0] SEL_C4 = 3'h4;
    localparam logic [2:0] SEL_C5 = 3'h5;
    localparam logic [2:0] SEL_C6 = 3'h6;
    localparam logic [2:0] SEL_C7 = 3'h7;

    // Pin positions in the synchroniser vectors
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_C = 2;
    localparam int PIN_D = 3;

    // Count sources
    typedef enum logic [3:0] {
        SRC_DIV1, SRC_DIV4, SRC_DIV16, SRC_DIV64, SRC_DIV256, SRC_DIV1024,
        SRC_PIN_A, SRC_PIN_B, SRC_PIN_C, SRC_PIN_D, SRC_CASCADE
    } tcs_src_e;

endpackage

// [core/tcs_clock_select.sv]
// Clock source selection and counters for timer channels 0 to 3.
// Assumes external pins are asynchronous; phase steps come from same-clock logic.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module tcs_clock_select
(
    // Clock and resets
    input  wire logic                         CORE_CLK,
    input  wire logic                         SYS_RST,
    input  wire logic                         STANDBY,
    input  wire logic                         MANUAL_RST,
    // Register port
    input  wire logic [tcs_pkg::ADDR_W-1:0]   REG_ADDR,
    input  wire logic [tcs_pkg::DATA_W-1:0]   REG_WDATA,
    input  wire logic                         REG_WR,
    input  wire logic                         REG_RD,
    output logic      [tcs_pkg::DATA_W-1:0]   REG_RDATA,
    // External clock pins
    input  wire logic                         EXT_CLK_PIN_A,
    input  wire logic                         EXT_CLK_PIN_B,
    input  wire logic                         EXT_CLK_PIN_C,
    input  wire logic                         EXT_CLK_PIN_D,
    // Phase counting steps for channels 1 and 2
    input  wire logic                         PHASE_STEP1,
    input  wire logic                         PHASE_UP1,
    input  wire logic                         PHASE_STEP2,
    input  wire logic                         PHASE_UP2,
    // Count events
    output logic      [tcs_pkg::NUM_CH-1:0]   CNT_TICK,
    output logic                              CHAN2_WRAP
);

    // Whole state of the block
    typedef struct packed {
        logic [tcs_pkg::NUM_CH-1:0][tcs_pkg::CTL_W-1:0] ctrl;
        logic [1:0]                                     mode;
        logic [tcs_pkg::PRE_W-1:0]                      presc;
        logic [3:0]                                     pin_s1;
        logic [3:0]                                     pin_s2;
        logic [3:0]                                     pin_s3;
        logic [tcs_pkg::NUM_CH-1:0][tcs_pkg::CNT_W-1:0] cnt;
        logic [tcs_pkg::NUM_CH-1:0]                     tick;
        logic                                           wrap2;
        logic [tcs_pkg::DATA_W-1:0]                     rdata;
    } tcs_state_s;

    tcs_state_s st_r;
    tcs_state_s st_nxt;

    // Per-channel select decode
    function automatic tcs_pkg::tcs_src_e src_of(input int ch, input logic [2:0] sel);
        tcs_pkg::tcs_src_e s;
        s = tcs_pkg::SRC_DIV1;
        case (ch)
            0:
            begin
                case (sel)
                    tcs_pkg::SEL_C1: s = tcs_pkg::SRC_DIV4;
                    tcs_pkg::SEL_C2: s = tcs_pkg::SRC_DIV16;
                    tcs_pkg::SEL_C3: s = tcs_pkg::SRC_DIV64;
                    tcs_pkg::SEL_C4: s = tcs_pkg::SRC_PIN_A;
                    tcs_pkg::SEL_C5: s = tcs_pkg::SRC_PIN_B;
                    tcs_pkg::SEL_C6: s = tcs_pkg::SRC_PIN_C;
                    tcs_pkg::SEL_C7: s = tcs_pkg::SRC_PIN_D;
                    default:         s = tcs_pkg::SRC_DIV1;
                endcase
            end
            1:
            begin
                case (sel)
                    tcs_pkg::SEL_C1: s = tcs_pkg::SRC_DIV4;
                    tcs_pkg::SEL_C2: s = tcs_pkg::SRC_DIV16;
                    tcs_pkg::SEL_C3: s = tcs_pkg::SRC_DIV64;
                    tcs_pkg::SEL_C4: s = tcs_pkg::SRC_PIN_A;
                    tcs_pkg::SEL_C5: s = tcs_pkg::SRC_PIN_B;
                    tcs_pkg::SEL_C6: s = tcs_pkg::SRC_DIV256;
                    tcs_pkg::SEL_C7: s = tcs_pkg::SRC_CASCADE;
                    default:         s = tcs_pkg::SRC_DIV1;
                endcase
            end
            2:
            begin
                case (sel)
                    tcs_pkg::SEL_C1: s = tcs_pkg::SRC_DIV4;
                    tcs_pkg::SEL_C2: s = tcs_pkg::SRC_DIV16;
                    tcs_pkg::SEL_C3: s = tcs_pkg::SRC_DIV64;
                    tcs_pkg::SEL_C4: s = tcs_pkg::SRC_PIN_A;
                    tcs_pkg::SEL_C5: s = tcs_pkg::SRC_PIN_B;
                    tcs_pkg::SEL_C6: s = tcs_pkg::SRC_PIN_C;
                    tcs_pkg::SEL_C7: s = tcs_pkg::SRC_DIV1024;
                    default:         s = tcs_pkg::SRC_DIV1;
                endcase
            end
            default:
            begin
                case (sel)
                    tcs_pkg::SEL_C1: s = tcs_pkg::SRC_DIV4;
                    tcs_pkg::SEL_C2: s = tcs_pkg::SRC_DIV16;
                    tcs_pkg::SEL_C3: s = tcs_pkg::SRC_DIV64;
                    tcs_pkg::SEL_C4: s = tcs_pkg::SRC_DIV256;
                    tcs_pkg::SEL_C5: s = tcs_pkg::SRC_DIV1024;
                    tcs_pkg::SEL_C6: s = tcs_pkg::SRC_PIN_A;
                    tcs_pkg::SEL_C7: s = tcs_pkg::SRC_PIN_B;
                    default:         s = tcs_pkg::SRC_DIV1;
                endcase
            end
        endcase
        return s;
    endfunction

    // Rising edge of a divided clock whose level is prescaler bit lg-1
    function automatic logic presc_rise(input logic [tcs_pkg::PRE_W-1:0] p, input int lg);
        logic [tcs_pkg::PRE_W-1:0] mask;
        mask = tcs_pkg::PRE_W'((1 << lg) - 1);
        return (p & mask) == (mask >> 1);
    endfunction

    // Falling edge of the same divided clock
    function automatic logic presc_fall(input logic [tcs_pkg::PRE_W-1:0] p, input int lg);
        logic [tcs_pkg::PRE_W-1:0] mask;
        mask = tcs_pkg::PRE_W'((1 << lg) - 1);
        return (p & mask) == mask;
    endfunction

    // Pick rising, falling or both according to the edge field
    function automatic logic edge_pick(input logic rise, input logic fall, input logic [1:0] edg);
        logic hit;
        if (edg[tcs_pkg::EDGE_BOTH_BIT])
            hit = rise | fall;
        else if (edg == tcs_pkg::EDGE_FALL)
            hit = fall;
        else
            hit = rise;
        return hit;
    endfunction

    // Divided source hit, with the edge choice applied
    function automatic logic div_hit(input logic [tcs_pkg::PRE_W-1:0] p, input int lg,
                                     input logic [1:0] edg);
        return edge_pick(presc_rise(p, lg), presc_fall(p, lg), edg);
    endfunction

    // Count enable for one source in this cycle
    function automatic logic src_hit(input tcs_pkg::tcs_src_e src,
                                     input logic [1:0] edg,
                                     input logic [tcs_pkg::PRE_W-1:0] p,
                                     input logic [3:0] prise,
                                     input logic [3:0] pfall,
                                     input logic casc);
        logic hit;
        case (src)
            tcs_pkg::SRC_DIV1:    hit = 1'b1;
            tcs_pkg::SRC_DIV4:    hit = div_hit(p, tcs_pkg::LG_DIV4, edg);
            tcs_pkg::SRC_DIV16:   hit = div_hit(p, tcs_pkg::LG_DIV16, edg);
            tcs_pkg::SRC_DIV64:   hit = div_hit(p, tcs_pkg::LG_DIV64, edg);
            tcs_pkg::SRC_DIV256:  hit = div_hit(p, tcs_pkg::LG_DIV256, edg);
            tcs_pkg::SRC_DIV1024: hit = div_hit(p, tcs_pkg::LG_DIV1024, edg);
            tcs_pkg::SRC_PIN_A:
                hit = edge_pick(prise[tcs_pkg::PIN_A], pfall[tcs_pkg::PIN_A], edg);
            tcs_pkg::SRC_PIN_B:
                hit = edge_pick(prise[tcs_pkg::PIN_B], pfall[tcs_pkg::PIN_B], edg);
            tcs_pkg::SRC_PIN_C:
                hit = edge_pick(prise[tcs_pkg::PIN_C], pfall[tcs_pkg::PIN_C], edg);
            tcs_pkg::SRC_PIN_D:
                hit = edge_pick(prise[tcs_pkg::PIN_D], pfall[tcs_pkg::PIN_D], edg);
            tcs_pkg::SRC_CASCADE: hit = casc;
            default:              hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Register address of a per-channel register
    function automatic logic [tcs_pkg::ADDR_W-1:0] addr_of(
        input logic [tcs_pkg::ADDR_W-1:0] base, input int ch);
        return tcs_pkg::ADDR_W'(base + tcs_pkg::ADDR_W'(ch));
    endfunction

    // Next-state logic
    always_comb
    begin
        logic [2:0]              sel;
        logic [1:0]              edg;
        logic [3:0]              prise;
        logic [3:0]              pfall;
        logic                    phase;
        logic                    hit;
        logic                    up;
        tcs_pkg::tcs_src_e       src;
        sel    = tcs_pkg::SEL_C0;
        edg    = tcs_pkg::EDGE_RISE;
        phase  = 1'b0;
        hit    = 1'b0;
        up     = 1'b1;
        src    = tcs_pkg::SRC_DIV1;
        st_nxt = st_r;

        // Pins pass two flops before any edge logic sees them
        st_nxt.pin_s1 = {EXT_CLK_PIN_D, EXT_CLK_PIN_C, EXT_CLK_PIN_B, EXT_CLK_PIN_A};
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.pin_s3 = st_r.pin_s2;
        prise = st_r.pin_s2 & ~st_r.pin_s3;
        pfall = ~st_r.pin_s2 & st_r.pin_s3;

        // One free-running prescaler feeds every divided source
        st_nxt.presc = tcs_pkg::PRE_W'(st_r.presc + tcs_pkg::PRE_ONE);
        st_nxt.tick  = '0;
        st_nxt.wrap2 = 1'b0;
        st_nxt.rdata = '0;

        // Channel counters; cascade uses last cycle's wrap to keep paths short
        for (int i = 0; i < tcs_pkg::NUM_CH; i++)
        begin
            sel = st_r.ctrl[i][tcs_pkg::SEL_MSB:tcs_pkg::SEL_LSB];
            edg = st_r.ctrl[i][tcs_pkg::EDGE_MSB:tcs_pkg::EDGE_LSB];
            src = src_of(i, sel);
            hit = src_hit(src, edg, st_r.presc, prise, pfall, st_r.wrap2);
            up  = 1'b1;
            phase = 1'b0;
            if (i == 1 && st_r.mode[tcs_pkg::MODE_PH1_BIT])
            begin
                phase = 1'b1;
                hit   = PHASE_STEP1;
                up    = PHASE_UP1;
            end
            if (i == 2 && st_r.mode[tcs_pkg::MODE_PH2_BIT])
            begin
                phase = 1'b1;
                hit   = PHASE_STEP2;
                up    = PHASE_UP2;
            end
            if (hit)
            begin
                st_nxt.tick[i] = 1'b1;
                if (up)
                    st_nxt.cnt[i] = tcs_pkg::CNT_W'(st_r.cnt[i] + tcs_pkg::CNT_ONE);
                else
                    st_nxt.cnt[i] = tcs_pkg::CNT_W'(st_r.cnt[i] - tcs_pkg::CNT_ONE);
                // Underflow only exists while counting down in phase mode
                if (i == 2 && ((up && st_r.cnt[i] == tcs_pkg::CNT_MAX) ||
                               (!up && phase && st_r.cnt[i] == tcs_pkg::CNT_ZERO)))
                    st_nxt.wrap2 = 1'b1;
            end
        end

        // Software writes; a write beats a count in the same cycle
        if (REG_WR)
        begin
            for (int i = 0; i < tcs_pkg::NUM_CH; i++)
            begin
                if (REG_ADDR == addr_of(tcs_pkg::ADDR_CTRL0, i))
                    st_nxt.ctrl[i] = REG_WDATA[tcs_pkg::CTL_W-1:0];
                if (REG_ADDR == addr_of(tcs_pkg::ADDR_CNT0, i))
                    st_nxt.cnt[i] = REG_WDATA[tcs_pkg::CNT_W-1:0];
            end
            if (REG_ADDR == tcs_pkg::ADDR_MODE)
                st_nxt.mode = REG_WDATA[1:0];
        end

        // Read data stands only in the cycle after the strobe
        if (REG_RD)
        begin
            for (int i = 0; i < tcs_pkg::NUM_CH; i++)
            begin
                if (REG_ADDR == addr_of(tcs_pkg::ADDR_CTRL0, i))
                    st_nxt.rdata = tcs_pkg::DATA_W'(st_r.ctrl[i]);
                if (REG_ADDR == addr_of(tcs_pkg::ADDR_CNT0, i))
                    st_nxt.rdata = st_r.cnt[i];
            end
            if (REG_ADDR == tcs_pkg::ADDR_MODE)
                st_nxt.rdata = tcs_pkg::DATA_W'(st_r.mode);
        end

        // Manual reset restarts counting but keeps the control setting
        if (MANUAL_RST)
        begin
            st_nxt.presc = '0;
            st_nxt.cnt   = '0;
            st_nxt.tick  = '0;
            st_nxt.wrap2 = 1'b0;
        end

        // Standby returns control to its power-on value
        if (STANDBY)
        begin
            for (int i = 0; i < tcs_pkg::NUM_CH; i++)
                st_nxt.ctrl[i] = tcs_pkg::CTRL_RST;
            st_nxt.mode = tcs_pkg::MODE_RST;
        end
    end

    // State register; power-on reset clears everything
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // Outputs straight from flops
    assign REG_RDATA  = st_r.rdata;
    assign CNT_TICK   = st_r.tick;
    assign CHAN2_WRAP = st_r.wrap2;

endmodule

`default_nettype wire

// [tb/tcs_pin_model.sv]
// Board-side model of the four external clock pins.
// Assumes the bench pulses go once per burst; pins idle low between bursts.
`timescale 1ns/1ns
`default_nettype none

module tcs_pin_model
(
    // Burst request from the bench
    input  wire logic       go,
    // External clock pins
    output logic      [3:0] pins
);
    initial
        pins = 4'h0;

    // Pulse j drives pins j and up, so pin A sees one pulse and pin D four
    // Rising edges are kept off the core clock grid on purpose; falling edges land on a clock edge
    always @(posedge go)
    begin
        #3;
        for (int j = 0; j < 4; j++)
        begin
            pins = 4'(4'hF << j);
            #47;
            pins = 4'h0;
            #43;
        end
    end
endmodule

`default_nettype wire

// [tb/tcs_clock_select_props.sv]
// Checker for the timer clock source select: readback, tick rates, phase and cascade.
// Sees only the top module's ports; keeps its own shadow of control and mode.
`timescale 1ns/1ns
`default_nettype none

module tcs_clock_select_props
(
    // Clock and resets
    input wire logic                         CORE_CLK,
    input wire logic                         SYS_RST,
    input wire logic                         STANDBY,
    input wire logic                         MANUAL_RST,
    // Register port
    input wire logic [tcs_pkg::ADDR_W-1:0]   REG_ADDR,
    input wire logic [tcs_pkg::DATA_W-1:0]   REG_WDATA,
    input wire logic                         REG_WR,
    input wire logic                         REG_RD,
    input wire logic [tcs_pkg::DATA_W-1:0]   REG_RDATA,
    // Phase steps and count events
    input wire logic                         PHASE_STEP1,
    input wire logic                         PHASE_STEP2,
    input wire logic [tcs_pkg::NUM_CH-1:0]   CNT_TICK,
    input wire logic                         CHAN2_WRAP
);
    logic [4:0]  ctl_sh [4];
    logic [1:0]  mode_sh;
    logic [11:0] hold [4];
    logic [10:0] gap [4];
    logic [3:0]  ok;
    logic [15:0] rd_exp;
    logic        rd_chk;

    // Quiet channel: no reset and no overwrite of its counter
    always_comb
        for (int i = 0; i < 4; i++)
            ok[i] = !SYS_RST && !MANUAL_RST && !(REG_WR && REG_ADDR == 4'(8 + i));

    // Shadows; hold counts undisturbed cycles, gap counts cycles since a tick
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST || STANDBY)
            mode_sh <= 2'h0;
        else if (REG_WR && REG_ADDR == tcs_pkg::ADDR_MODE)
            mode_sh <= REG_WDATA[1:0];
        rd_chk <= REG_RD && !SYS_RST && REG_ADDR[3:2] != 2'h2;
        rd_exp <= (REG_ADDR == tcs_pkg::ADDR_MODE) ? {14'h0000, mode_sh} :
                  (REG_ADDR[3:2] == 2'h0) ? {11'h000, ctl_sh[REG_ADDR[1:0]]} : 16'h0000;
        for (int i = 0; i < 4; i++)
        begin
            if (SYS_RST || STANDBY)
                ctl_sh[i] <= 5'h00;
            else if (REG_WR && REG_ADDR == 4'(i))
                ctl_sh[i] <= REG_WDATA[4:0];
            if (!ok[i] || STANDBY || (REG_WR && REG_ADDR[3:2] == 2'h0 && REG_ADDR[1:0] == 2'(i)))
                hold[i] <= 12'h000;
            else if (REG_WR && REG_ADDR == tcs_pkg::ADDR_MODE)
                hold[i] <= 12'h000;
            else if (hold[i] != 12'hFFF)
                hold[i] <= hold[i] + 12'h001;
            gap[i] <= CNT_TICK[i] ? 11'h000 : gap[i] + 11'h001;
        end
    end

    a_rdata_idle_zero: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        !$past(REG_RD) |-> REG_RDATA == 16'h0000) else $error("read data not idle");
    a_ctrl_readback: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        rd_chk |-> REG_RDATA == rd_exp) else $error("register readback wrong");
    a_reset_quiet: assert property (@(posedge CORE_CLK)
        SYS_RST |=> CNT_TICK == 4'h0 && !CHAN2_WRAP) else $error("ticks after reset");
    a_div1_every_cycle: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        ctl_sh[0][2:0] == 3'h0 && ok[0] |=> CNT_TICK[0]) else $error("undivided tick missed");
    a_div4_gap: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        CNT_TICK[3] && ctl_sh[3] == 5'h01 && hold[3] > 5 |-> gap[3] == 11'h003)
        else $error("divide by 4 spacing wrong");
    a_div16_gap: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        CNT_TICK[2] && ctl_sh[2] == 5'h02 && !mode_sh[1] && hold[2] > 36 |-> gap[2] == 11'h00F)
        else $error("divide by 16 spacing wrong");
    a_div256_gap: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        CNT_TICK[1] && ctl_sh[1] == 5'h06 && !mode_sh[0] && hold[1] > 516 |-> gap[1] == 11'h0FF)
        else $error("divide by 256 spacing wrong");
    a_div1024_gap: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        CNT_TICK[2] && ctl_sh[2] == 5'h07 && !mode_sh[1] && hold[2] > 2052 |-> gap[2] == 11'h3FF)
        else $error("divide by 1024 spacing wrong");
    a_cascade_follow: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        ctl_sh[1][2:0] == 3'h7 && !mode_sh[0] && ok[1] |=> CNT_TICK[1] == $past(CHAN2_WRAP))
        else $error("cascade tick wrong");
    a_phase1_steps: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        mode_sh[0] && ok[1] |=> CNT_TICK[1] == $past(PHASE_STEP1)) else $error("phase 1 tick wrong");
    a_phase2_steps: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        mode_sh[1] && ok[2] |=> CNT_TICK[2] == $past(PHASE_STEP2)) else $error("phase 2 tick wrong");
endmodule

bind tcs_clock_select tcs_clock_select_props u_props (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
    .STANDBY(STANDBY), .MANUAL_RST(MANUAL_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PHASE_STEP1(PHASE_STEP1),
    .PHASE_STEP2(PHASE_STEP2), .CNT_TICK(CNT_TICK), .CHAN2_WRAP(CHAN2_WRAP));

`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the timer clock source select.
// Drives registers, resets and phase steps; the pin model drives the clock pins.
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("unexpected %s: expected %h seen %h", nm, exp, got); end end

module testbench;
    logic        CORE_CLK, SYS_RST, STANDBY, MANUAL_RST, REG_WR, REG_RD, pin_go;
    logic        PHASE_STEP1, PHASE_UP1, PHASE_STEP2, PHASE_UP2, CHAN2_WRAP;
    logic [3:0]  REG_ADDR, CNT_TICK, pins;
    logic [15:0] REG_WDATA, REG_RDATA, v0, v1, w0, w1;
    int          error_cnt = 0;
    int          total_checks = 0;
    // Per channel and code: divider, or minus pin number plus one, or 0 for cascade
    int          tbl [4][8] = '{'{1, 4, 16, 64, -1, -2, -3, -4}, '{1, 4, 16, 64, -1, -2, 256, 0},
                                '{1, 4, 16, 64, -1, -2, -3, 1024}, '{1, 4, 16, 64, 256, 1024, -1, -2}};

    tcs_clock_select dut (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .STANDBY(STANDBY),
        .MANUAL_RST(MANUAL_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .EXT_CLK_PIN_A(pins[0]), .EXT_CLK_PIN_B(pins[1]),
        .EXT_CLK_PIN_C(pins[2]), .EXT_CLK_PIN_D(pins[3]), .PHASE_STEP1(PHASE_STEP1),
        .PHASE_UP1(PHASE_UP1), .PHASE_STEP2(PHASE_STEP2), .PHASE_UP2(PHASE_UP2),
        .CNT_TICK(CNT_TICK), .CHAN2_WRAP(CHAN2_WRAP));
    tcs_pin_model pin_model (.go(pin_go), .pins(pins));

    // 100 MHz clock
    initial
    begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end

    // One-cycle write and read strobes; read data stands in the following cycle only
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CORE_CLK);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        #1 d = REG_RDATA;
    endtask

    // Counts of one channel over exactly win cycles between the two reads
    task automatic rate(input int ch, input logic [15:0] ctl, input int win,
                        output logic [15:0] d);
        wr(4'(ch), ctl);
        rd(4'(8 + ch), v0);
        repeat (win - 2) @(posedge CORE_CLK);
        rd(4'(8 + ch), v1);
        d = v1 - v0;
    endtask

    // Reset values, field width, independence, manual reset and standby
    task automatic t_regs;
        for (int i = 0; i < 5; i++)
        begin
            rd(4'(i), v0);
            `CHK("reset value", 16'h0000, v0)
        end
        for (int i = 0; i < 4; i++)
            wr(4'(i), 16'hFF18 + 16'(i));
        @(posedge CORE_CLK);
        MANUAL_RST <= 1'b1;
        @(posedge CORE_CLK);
        MANUAL_RST <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            rd(4'(i), v0);
            `CHK("control kept", 16'h0018 + 16'(i), v0)
        end
        @(posedge CORE_CLK);
        STANDBY <= 1'b1;
        @(posedge CORE_CLK);
        STANDBY <= 1'b0;
        rd(4'h3, v0);
        `CHK("control after standby", 16'h0000, v0)
        rd(4'hF, v1);
        `CHK("unmapped read", 16'h0000, v1)
        $display("t_regs done");
    endtask

    // Both edges double a divided rate, falling edge keeps it; edge choice is ignored on the undivided clock
    task automatic t_edges;
        rate(0, 16'h0011, 12, w0);
        `CHK("both edges div4", 16'h0006, w0)
        rate(0, 16'h0009, 12, w0);
        `CHK("falling edge div4", 16'h0003, w0)
        rate(0, 16'h0010, 12, w0);
        `CHK("both edges div1", 16'h000C, w0)
        $display("t_edges done");
    endtask

    // Every divider and every pin choice on every channel
    task automatic t_sources;
        for (int ch = 0; ch < 4; ch++)
            for (int c = 0; c < 8; c++)
                if (tbl[ch][c] > 0)
                begin
                    rate(ch, 16'(c), 3 * tbl[ch][c], w0);
                    `CHK("divided count", 16'h0003, w0)
                end
                else if (tbl[ch][c] < 0)
                begin
                    wr(4'(ch), 16'(c));
                    rd(4'(8 + ch), v0);
                    @(posedge CORE_CLK);
                    pin_go <= 1'b1;
                    @(posedge CORE_CLK);
                    pin_go <= 1'b0;
                    repeat (60) @(posedge CORE_CLK);
                    rd(4'(8 + ch), v1);
                    `CHK("pin count", 16'(-tbl[ch][c]), 16'(v1 - v0))
                end
        $display("t_sources done");
    endtask

    // Channel 1 counts one step per channel 2 wrap
    task automatic t_cascade;
        wr(4'h1, 16'h0007);
        wr(4'h2, 16'h0000);
        wr(4'hA, 16'h0000);
        rd(4'h9, v0);
        wr(4'hA, 16'hFFF0);
        repeat (40) @(posedge CORE_CLK);
        rd(4'h9, v1);
        `CHK("cascade count", 16'h0001, 16'(v1 - v0))
        $display("t_cascade done");
    endtask

    // Phase mode: steps count, the select codes left in place do not
    task automatic t_phase;
        wr(4'h1, 16'h0000);
        wr(4'h4, 16'h0003);
        rd(4'h9, v0);
        rd(4'hA, w0);
        for (int k = 0; k < 3; k++)
        begin
            @(posedge CORE_CLK);
            PHASE_STEP1 <= 1'b1;
            PHASE_UP1   <= 1'b1;
            PHASE_STEP2 <= (k < 2);
            @(posedge CORE_CLK);
            PHASE_STEP1 <= 1'b0;
            PHASE_STEP2 <= 1'b0;
        end
        rd(4'h9, v1);
        rd(4'hA, w1);
        `CHK("phase up count", 16'h0003, 16'(v1 - v0))
        `CHK("phase down count", 16'hFFFE, 16'(w1 - w0))
        wr(4'h4, 16'h0000);
        $display("t_phase done");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence after a 16-cycle reset
    initial
    begin
        {SYS_RST, STANDBY, MANUAL_RST, REG_WR, REG_RD, pin_go} = 6'h20;
        {PHASE_STEP1, PHASE_UP1, PHASE_STEP2, PHASE_UP2} = 4'h0;
        REG_ADDR  = 4'h0;
        REG_WDATA = 16'h0000;
        repeat (16) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        t_regs;
        t_edges;
        t_sources;
        t_cascade;
        t_phase;
        summarize;
    end

    // Watchdog: the tests need roughly 10k cycles
    initial
    begin
        #600000;
        error_cnt++;
        summarize;
    end
endmodule

`default_nettype wire
